// ### rtl/row_scan_sequencer.sv
// vertical sequencer and row driver control with an apb register port
// Operation
// - rows are picked by a 600-stage token shift register, row 1 on top
// - direction comes from the pin, or from the register bit when source bit set
// - direction low scans upward in row number, high scans downward
// - format field decodes to progressive, interlaced or pseudo-interlaced 600 or 480
// - reversed scans mirror start and end rows about the array centre
// - sync, field and line clock come in from sync logic, settings from registers
// - line pulses are counted and the window opens when count equals start value
// - scanning stops when the token leaves the chain, until the next start
// - interlaced fields pick odd or even rows from the field polarity
// - progressive formats address each row once per active line
// - interlaced formats address every other row, others stay unselected
// - pseudo-interlaced drives row pairs, even field offset by one, first row skipped
// - the start stage is chosen per format so scans start and end elsewhere
// - the row chain is cleared at every frame boundary
// - outside full progressive 600 and interlaced 480, inactive rows are forced black
// - the chain advances once per line on the line clock
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "row_scan_consts.svh"
module row_scan_sequencer
  import row_scan_pkg::*;
#(
  parameter int NUM_ROWS = `RS_NUM_ROWS,
  parameter int START_W = `RS_START_W
) (
  input wire logic pclk, // 25 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire sync_in_t sync_in, // vsync, field, line tick from sync logic
  input wire logic scan_dir_pin, // external up/down pin
  output logic [NUM_ROWS-1:0] row_select, // selected rows
  output logic [NUM_ROWS-1:0] row_black, // rows forced to black
  output logic scan_active // token still in the chain
);
  ////////////////////////////////////////////////////////////////
  // registers
  scan_cfg_t vertical_scan_config;
  logic [START_W-1:0] vertical_window_start;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [31:0] status_word;
  seq_state_t state;
  seq_state_t next_state;
  logic [START_W-1:0] line_count;
  logic [9:0] lines_left;
  logic field_q;
  logic first_line;
  logic vsync_q;
  logic vsync_rise;
  logic dir_eff;
  logic start_strobe;
  logic end_scan;
  logic chain_clear;
  logic [NUM_ROWS-1:0] chain;
  logic [NUM_ROWS-1:0] partner;
  logic [NUM_ROWS-1:0] next_select;
  logic [NUM_ROWS-1:0] next_black;
  vertical_format_select_t fmt;
  logic step_two;

  function automatic logic is_480(input vertical_format_select_t f);
    is_480 = (f == FMT_PROG480) || (f == FMT_INT480) || (f == FMT_PSEUDO480);
  endfunction

  function automatic logic is_int(input vertical_format_select_t f);
    is_int = (f == FMT_INT600) || (f == FMT_INT480);
  endfunction

  function automatic logic is_pseudo(input vertical_format_select_t f);
    is_pseudo = (f == FMT_PSEUDO600) || (f == FMT_PSEUDO480);
  endfunction

  // top-to-bottom start index, mirrored when reversed
  function automatic logic [9:0] start_index(input vertical_format_select_t f, input logic odd, input logic rev);
    logic [9:0] idx;
    idx = is_480(f) ? 10'(`RS_OFFSET_480) : 10'h000;
    if ((is_int(f) || is_pseudo(f)) && !odd)
      idx = idx + 10'h001;
    start_index = rev ? 10'(NUM_ROWS - 1) - idx : idx;
  endfunction

  function automatic logic [9:0] field_lines(input vertical_format_select_t f);
    logic [9:0] n;
    n = is_480(f) ? 10'(`RS_ROWS_480) : 10'(NUM_ROWS);
    field_lines = (is_int(f) || is_pseudo(f)) ? (n >> 1) : n;
  endfunction

  assign fmt = vertical_scan_config.vertical_format_select;
  // interlaced and pair scans skip a stage each line
  assign step_two = is_int(fmt) || is_pseudo(fmt);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `RS_ADDR_CONFIG) || (paddr == `RS_ADDR_START) || (paddr == `RS_ADDR_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign status_word = {16'h0000, lines_left, 2'h0, state == ST_SCAN, field_q, dir_eff, scan_active};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vertical_scan_config <= `RS_CONFIG_RESET;
    else if (wr_en && paddr == `RS_ADDR_CONFIG)
      vertical_scan_config <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vertical_window_start <= `RS_START_RESET;
    else if (wr_en && paddr == `RS_ADDR_START)
      vertical_window_start <= pwdata[START_W-1:0];
  end

  // read data captured in the setup cycle, zero wait access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
    begin
      unique case (paddr)
        `RS_ADDR_CONFIG: prdata <= {24'h000000, vertical_scan_config};
        `RS_ADDR_START: prdata <= 32'(vertical_window_start);
        `RS_ADDR_STATUS: prdata <= status_word;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // direction and frame sync
  // direction source select
  assign dir_eff = vertical_scan_config.vertical_direction_source ? vertical_scan_config.vertical_direction_bit
                                                                  : scan_dir_pin;

  // sync inputs from the sync logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vsync_q <= 1'b0;
    else
      vsync_q <= sync_in.vsync;
  end

  assign vsync_rise = sync_in.vsync && !vsync_q;

  // field latched with vertical sync
  // reset to odd, so a scan before the first sync takes odd rows
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      field_q <= 1'b1;
    else if (vsync_rise)
      field_q <= sync_in.field;
  end

  ////////////////////////////////////////////////////////////////
  // sequencer state
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_WAIT: if (vsync_rise) next_state = ST_COUNT;
      ST_COUNT: if (start_strobe) next_state = ST_SCAN;
      ST_SCAN: if (end_scan) next_state = ST_WAIT;
      default: next_state = ST_WAIT;
    endcase
    if (vsync_rise)
      next_state = ST_COUNT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_WAIT;
    else
      state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_count <= '0;
    else if (vsync_rise)
      line_count <= '0;
    else if (state == ST_COUNT && sync_in.line_tick)
      line_count <= line_count + START_W'(1);
  end

  // window opens on a count match
  assign start_strobe = (state == ST_COUNT) && !vsync_rise && (line_count == vertical_window_start);

  // stop when the field length or the chain runs out
  // length guard ends a field even when no new sync arrives
  assign end_scan = (state == ST_SCAN) && sync_in.line_tick && ((lines_left == 10'h001) || !scan_active);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lines_left <= 10'h000;
    else if (start_strobe)
      lines_left <= field_lines(fmt);
    else if (state == ST_SCAN && sync_in.line_tick && lines_left != 10'h000)
      lines_left <= lines_left - 10'h001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_line <= 1'b0;
    else if (start_strobe)
      first_line <= 1'b1;
    else if (sync_in.line_tick || vsync_rise)
      first_line <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // row chain
  // chain cleared at the frame boundary
  // clearing on sync too means a cut frame leaves no stray token
  assign chain_clear = vsync_rise || end_scan;

  // token chain loaded at the format start stage, stepped per line
  row_stage_chain #(
    .STAGES(NUM_ROWS)
  ) u_chain (
    .pclk(pclk),
    .presetn(presetn),
    .clear(chain_clear),
    .load(start_strobe),
    .load_pos(start_index(fmt, field_q, dir_eff)),
    .advance(state == ST_SCAN && sync_in.line_tick),
    .step2(step_two),
    .reverse(dir_eff),
    .stages(chain)
  );

  assign scan_active = |chain;
  // pair partner is the next row in scan direction
  assign partner = dir_eff ? (chain >> 1) : (chain << 1);

  always_comb
  begin
    next_select = chain;
    // pairs, first row of the even field left off
    if (is_pseudo(fmt))
      next_select = (first_line && !field_q) ? partner : (chain | partner);
    // single token, other rows stay unselected
    // black outside the window unless full progressive or interlaced 480
    next_black = '0;
    if (fmt == FMT_PROG480 || is_pseudo(fmt) || fmt == FMT_INT600)
      for (int i = 0; i < NUM_ROWS; i++)
        next_black[i] = is_480(fmt) && (i < `RS_OFFSET_480 || i >= `RS_OFFSET_480 + `RS_ROWS_480);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      row_select <= '0;
    else
      row_select <= next_select;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      row_black <= '0;
    else
      row_black <= next_black;
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    start_strobe;
  endsequence

  sequence s_one_token;
    $onehot(chain);
  endsequence

  sequence s_line_step;
    state == ST_SCAN && sync_in.line_tick && !chain_clear;
  endsequence

  a_dir_source: assert property (s_line_step ##0 (vertical_scan_config.vertical_direction_source
    && vertical_scan_config.vertical_direction_bit) |=> chain == ($past(chain) >> ($past(step_two) ? 2 : 1)))
    else $error("register direction not obeyed");
  a_start_match: assert property (state == ST_COUNT && !vsync_rise && line_count == vertical_window_start
    |=> state == ST_SCAN ##0 s_one_token) else $error("window did not open on count match");
  a_start_load: assert property (s_start ##1 !vsync_rise[*1] |-> s_one_token)
    else $error("start did not load one token");
  a_mirror_start: assert property (start_strobe && dir_eff && fmt == FMT_PROG600A ##1 1'b1
    |-> chain[NUM_ROWS-1] || $past(vsync_rise)) else $error("reverse start not at bottom");
  a_frame_clear: assert property (vsync_rise |=> chain == '0)
    else $error("chain not cleared at frame");
  a_sync_count: assert property (vsync_rise |=> line_count == '0)
    else $error("counter not cleared on sync");
  a_prog_step: assert property (state == ST_SCAN && sync_in.line_tick && fmt == FMT_PROG600A && !dir_eff
    && !chain_clear |=> chain == ($past(chain) << 1)) else $error("progressive step wrong");
  a_end_stop: assert property (end_scan |=> chain == '0 && state != ST_SCAN)
    else $error("scan did not stop");
  a_black_full: assert property (fmt == FMT_PROG600A ##1 fmt == FMT_PROG600A |-> row_black == '0)
    else $error("black forced in full format");
  a_pseudo_first: assert property (is_pseudo(fmt) && first_line && !field_q && $stable(fmt)
    |=> (row_select & $past(chain)) == '0) else $error("even first row selected");
  a_int_parity: assert property (is_int(fmt) && state == ST_SCAN && !dir_eff && field_q
    |-> (chain & {NUM_ROWS/2{2'b10}}) == '0) else $error("odd field hit even row");
  a_apb_error: assert property (psel && penable && !mapped |-> (pslverr && pready) ##1
    ($stable(vertical_scan_config) && $stable(vertical_window_start))) else $error("unmapped access not refused");

  // idle, line pulse, field, token, blanking and pair checks
  a_wait_empty: assert property (state == ST_WAIT |-> !scan_active)
    else $error("token alive while waiting");
  a_line_only: assert property (state == ST_SCAN && !sync_in.line_tick && !chain_clear
    |=> $stable(chain)) else $error("chain moved without a line pulse");
  a_field_latch: assert property (vsync_rise |=> field_q == $past(sync_in.field))
    else $error("field polarity not taken at sync");
  a_count_hold: assert property (state == ST_COUNT && !sync_in.line_tick && !vsync_rise
    |=> $stable(line_count)) else $error("counter moved without a line pulse");
  a_one_row: assert property (state == ST_SCAN && !step_two |-> $onehot0(chain))
    else $error("more than one row token");
  a_black_480: assert property (fmt == FMT_PROG480 ##1 fmt == FMT_PROG480
    |-> row_black[0] && !row_black[`RS_OFFSET_480] && row_black[NUM_ROWS-1]) else $error("480 window not blanked");
  a_pair_rows: assert property (is_pseudo(fmt) && !first_line
    |=> row_select == ($past(chain) | $past(partner))) else $error("pair rows not driven together");
  a_int_even: assert property (is_int(fmt) && state == ST_SCAN && !dir_eff && !field_q
    |-> (chain & {NUM_ROWS/2{2'b01}}) == '0) else $error("even field hit odd row");
endmodule

// ### rtl/row_scan_consts.svh
// offsets, field positions, reset values and counts of the row scan sequencer
`ifndef ROW_SCAN_CONSTS_SVH
`define ROW_SCAN_CONSTS_SVH
`define RS_NUM_ROWS 600
`define RS_ROWS_480 480
`define RS_OFFSET_480 60
`define RS_START_W 10
`define RS_ADDR_CONFIG 12'h000
`define RS_ADDR_START 12'h004
`define RS_ADDR_STATUS 12'h008
`define RS_FMT_LSB 2
`define RS_DIR_BIT 5
`define RS_DIR_SRC_BIT 6
`define RS_CONFIG_RESET 8'h00
`define RS_START_RESET 10'h000
`endif

// ### rtl/row_scan_pkg.sv
// types shared by the row scan sequencer files
package row_scan_pkg;
  typedef enum logic [2:0] {
    FMT_PROG600A = 3'b000,
    FMT_PROG480 = 3'b001,
    FMT_INT600 = 3'b010,
    FMT_PSEUDO600 = 3'b011,
    FMT_INT480 = 3'b100,
    FMT_PSEUDO480 = 3'b101,
    FMT_PROG600B = 3'b110,
    FMT_PROG600C = 3'b111
  } vertical_format_select_t;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_COUNT = 3'b010,
    ST_SCAN = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic vsync;
    logic field;
    logic line_tick;
  } sync_in_t;
  typedef struct packed {
    logic spare_top;
    logic vertical_direction_source;
    logic vertical_direction_bit;
    vertical_format_select_t vertical_format_select;
    logic [1:0] spare;
  } scan_cfg_t;
endpackage

// ### rtl/row_stage_chain.sv
// bidirectional row token shift register with a loadable start stage
`timescale 1ns/100ps
module row_stage_chain #(
  parameter int STAGES = 600
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic clear, // drop every token
  input wire logic load, // place one token at load_pos
  input wire logic [9:0] load_pos, // stage index, 0 = row 1
  input wire logic advance, // one line period elapsed
  input wire logic step2, // move two stages per line
  input wire logic reverse, // shift toward lower rows
  output logic [STAGES-1:0] stages // token per stage
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stages <= '0;
    else if (clear)
      stages <= '0;
    else if (load)
      stages <= STAGES'(1) << load_pos;
    else if (advance)
    begin
      // tokens shifted past either end are simply lost
      if (reverse)
        stages <= step2 ? (stages >> 2) : (stages >> 1);
      else
        stages <= step2 ? (stages << 2) : (stages << 1);
    end
  end
endmodule

// ### verification/sync_source_model.sv
// behavioural sync source: vsync, field level and line pulses for one frame
`timescale 1ns/100ps
module sync_source_model
  import row_scan_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic go, // start a frame, restarts a running one
  input wire logic field_odd, // polarity of the new field
  input wire logic [9:0] lines, // line pulses to send
  output sync_in_t sync_in, // towards the sequencer
  output logic busy // frame still running
);
  logic [9:0] left;
  logic [2:0] phase;
  ////////////////////////////////
  // frame pacing
  // pulses eight cycles apart; caller keeps interlaced fields at 240 to 300 lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_in <= '0;
      left <= '0;
      phase <= '0;
      busy <= 1'b0;
    end
    else if (go)
    begin
      sync_in <= '{vsync: 1'b1, field: field_odd, line_tick: 1'b0};
      left <= lines;
      phase <= '0;
      busy <= 1'b1;
    end
    else
    begin
      phase <= phase + 3'h1;
      sync_in.line_tick <= busy && phase == 3'h7 && left != 10'h000;
      if (phase == 3'h2)
        sync_in.vsync <= 1'b0;
      if (phase == 3'h7 && left != 10'h000)
        left <= left - 10'h001;
      if (phase == 3'h7 && left == 10'h000)
        busy <= 1'b0;
    end
  end
endmodule

// ### verification/test_row_scan_sequencer.sv
// self-checking bench for the row scan sequencer
`timescale 1ns/100ps
`include "row_scan_consts.svh"
module test_row_scan_sequencer
  import row_scan_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_active, scan_dir_pin, go, field_odd, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] lines;
  logic [599:0] row_select, row_black;
  sync_in_t sync_in;
  int miscompares, comparisons, seed;
  row_scan_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_in(sync_in),
    .scan_dir_pin(scan_dir_pin), .row_select(row_select), .row_black(row_black), .scan_active(scan_active));
  sync_source_model sync_src (.pclk(pclk), .presetn(presetn), .go(go), .field_odd(field_odd), .lines(lines),
    .sync_in(sync_in), .busy(busy));
  ////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_rows(input logic [599:0] got, input logic [599:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t row vector mismatch", $time);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////
  // interlaced fields kept at 240 to 300 lines
  function automatic int nlines(input logic [2:0] f);
    if (f == FMT_INT600 || f == FMT_PSEUDO600)
      return 300;
    if (f == FMT_INT480 || f == FMT_PSEUDO480)
      return 240;
    return (f == FMT_PROG480) ? `RS_ROWS_480 : `RS_NUM_ROWS;
  endfunction
  function automatic logic [599:0] exp_rows(input logic [2:0] f, input logic rev, input logic odd, input int ln);
    logic [599:0] v;
    int base, a, b;
    v = '0;
    base = (f == FMT_PROG480 || f == FMT_INT480 || f == FMT_PSEUDO480) ? `RS_OFFSET_480 : 0;
    if (ln < 0 || ln >= nlines(f))
      return v;
    a = base + ln;
    b = -1;
    if (f == FMT_INT600 || f == FMT_INT480 || f == FMT_PSEUDO600 || f == FMT_PSEUDO480)
      a = base + 2 * ln + (odd ? 0 : 1);
    if (f == FMT_PSEUDO600 || f == FMT_PSEUDO480)
      b = a + 1;
    // even field of a pair scan skips its first row
    if (b >= 0 && !odd && ln == 0)
      a = -1;
    if (a >= 0 && a < `RS_NUM_ROWS)
      v[rev ? `RS_NUM_ROWS - 1 - a : a] = 1'b1;
    if (b >= 0 && b < `RS_NUM_ROWS)
      v[rev ? `RS_NUM_ROWS - 1 - b : b] = 1'b1;
    return v;
  endfunction
  function automatic logic [599:0] exp_black(input logic [2:0] f);
    logic [599:0] v;
    for (int k = 0; k < `RS_NUM_ROWS; k++)
      v[k] = (f == FMT_PROG480 || f == FMT_PSEUDO480) && (k < 60 || k >= 540);
    return v;
  endfunction
  ////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      $display("[ERR] %0t no ready on the register port", $time);
      miscompares++;
      final_report();
    end
  endtask
  // one field: vsync, then ticks; rows checked settled before each next pulse
  task automatic frame(input logic [2:0] f, input logic rev, input logic odd, input int s, input int ticks);
    logic [599:0] v;
    int k;
    go <= 1'b1;
    field_odd <= odd;
    lines <= 10'(ticks);
    @(posedge pclk);
    go <= 1'b0;
    for (int t = 0; t <= ticks; t++)
    begin
      k = 0;
      while (t > 0 && sync_in.line_tick !== 1'b1 && k < 40)
      begin
        @(posedge pclk);
        k++;
      end
      if (k >= 40)
      begin
        $display("[ERR] %0t no line pulse", $time);
        miscompares++;
        final_report();
      end
      repeat (5) @(posedge pclk);
      v = exp_rows(f, rev, odd, t - s);
      chk_rows(row_select, v);
      chk_rows(row_black, exp_black(f));
      chk_word({31'h0, scan_active}, {31'h0, |v});
    end
  endtask
  ////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    logic [31:0] rd, cfg;
    logic err, src, pin, odd, dir;
    logic [2:0] f;
    int s;
    {presetn, psel, penable, pwrite, scan_dir_pin, go, field_odd} = '0;
    {paddr, pwdata, lines, miscompares, comparisons} = '0;
    seed = 32'h4965;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RS_ADDR_CONFIG, 32'h0, rd, err);
    chk_word(rd, 32'(`RS_CONFIG_RESET));
    apb(1'b0, `RS_ADDR_START, 32'h0, rd, err);
    chk_word(rd, 32'(`RS_START_RESET));
    chk_word({31'h0, err}, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, rd, err);
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk_word({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 10; i++)
    begin
      rd = $random(seed);
      f = (i < 8) ? 3'(i) : rd[4:2];
      src = i[0];
      pin = rd[9];
      odd = rd[10];
      s = 1 + (rd[13:11] & 7);
      cfg = {24'h000000, rd[7], src, rd[5], f, rd[1:0]};
      apb(1'b1, `RS_ADDR_CONFIG, cfg, rd, err);
      apb(1'b0, `RS_ADDR_CONFIG, 32'h0, rd, err);
      chk_word(rd, cfg);
      apb(1'b1, `RS_ADDR_START, 32'(s), rd, err);
      scan_dir_pin <= pin;
      dir = src ? cfg[5] : pin;
      if (i == 0)
        frame(f, pin, odd, s, s + 5);
      frame(f, dir, odd, s, s + nlines(f) + 1);
      apb(1'b0, `RS_ADDR_STATUS, 32'h0, rd, err);
      chk_word(rd, {29'h0, odd, dir, 1'b0});
    end
    final_report();
  end
endmodule
